// ==== hdl/tw_mem_cfg.svh ====
`ifndef TW_MEM_CFG_SVH
`define TW_MEM_CFG_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define TW_ADDR_W 11
`define TW_DEPTH 2048
`define TW_ADDR_RST 11'h000
`define TW_ADDR_ONE 11'h001

// ----------------------------------------
// serial byte framing
// ----------------------------------------
`define TW_LAST_BIT 4'h7
`define TW_ACK_BIT 4'h8
`define TW_CNT_ONE 4'h1
`define TW_CNT_RST 4'h0
`define TW_BYTE_RST 8'h00

// device-type code; value is arbitrary
`define TW_DEV_TYPE_DEF 4'h5

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define TW_REG_STATUS 32'h0000_0000
`define TW_REG_CTRL 32'h0000_0004
`define TW_CTRL_RST 32'h0000_0001
`define TW_CTRL_EN_BIT 0
`define TW_ST_BUSY_BIT 16
`define TW_ST_WP_BIT 17
`define TW_WORD_RST 32'h0000_0000

`endif

// ==== hdl/tw_mem_pkg.sv ====
package tw_mem_pkg;

    // protocol states of the serial front end
    typedef enum logic [3:0] {
        TW_IDLE = 4'h0,
        TW_DEV = 4'h1,
        TW_WORD = 4'h2,
        TW_WR = 4'h3,
        TW_ACK = 4'h4,
        TW_RD = 4'h5,
        TW_RACK = 4'h6,
        TW_SKIP = 4'h7
    } tw_state_e;

    // pin inputs, all from outside the clock domain
    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
    } tw_pins_s;

    // classic wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } tw_wb_req_s;

endpackage

// ==== hdl/tw_mem_slave.sv ====
`timescale 1ns/1ns
`include "tw_mem_cfg.svh"

module tw_mem_slave #(
    parameter logic [3:0] DEV_TYPE = `TW_DEV_TYPE_DEF
) (
    input wire logic clock,
    input wire logic srst,
    input wire tw_mem_pkg::tw_pins_s pins,
    output logic sda_level,
    output logic sda_oe_n,
    input wire tw_mem_pkg::tw_wb_req_s wb_req,
    output logic wb_ack,
    output logic [31:0] wb_rdat
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    tw_mem_pkg::tw_pins_s pin_s1_q;
    tw_mem_pkg::tw_pins_s pin_s2_q;
    logic scl_p_q;
    logic sda_p_q;
    tw_mem_pkg::tw_state_e state_q;
    tw_mem_pkg::tw_state_e nxt_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic ack_ok_q;
    logic ack_on_q;
    logic oe_n_q;
    logic [`TW_ADDR_W-1:0] addr_q;
    logic [7:0] mem [`TW_DEPTH];
    logic [31:0] ctrl_q;
    logic wb_ack_q;
    logic [31:0] wb_dat_q;
    logic [31:0] status;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic bit_in;
    logic wp_on;
    logic [7:0] rx_byte;
    logic byte_done;
    logic dev_hit;
    logic wr_commit;
    logic rd_done;
    logic enable;
    logic wb_req_hit;

    // states that shift a byte in from the master
    function automatic logic is_rx(input tw_mem_pkg::tw_state_e s);
        is_rx = (s == tw_mem_pkg::TW_DEV) || (s == tw_mem_pkg::TW_WORD) || (s == tw_mem_pkg::TW_WR);
    endfunction

    // pick the outgoing bit for a count, msb first
    function automatic logic bit_sel(input logic [7:0] b, input logic [3:0] c);
        logic [3:0] idx;
        idx = `TW_LAST_BIT - c;
        bit_sel = b[idx[2:0]];
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // lines reset to their released level so no false edge follows reset;
    // protect resets to low so an undriven pin reads unprotected
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_s1_q <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
            pin_s2_q <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
        end else begin
            pin_s1_q <= pins;
            pin_s2_q <= pin_s1_q;
        end
    end

    // delayed copy for edge finding; reads only the second stage
    always_ff @(posedge clock) begin
        if (srst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= pin_s2_q.scl;
            sda_p_q <= pin_s2_q.sda;
        end
    end

    // ----------------------------------------
    // bus conditions
    // ----------------------------------------
    // scl is only ever sampled; the block never makes a clock
    assign scl_rise = pin_s2_q.scl & ~scl_p_q;
    assign scl_fall = ~pin_s2_q.scl & scl_p_q;
    // sda edges while scl stays high are framing, not data
    assign start_ev = pin_s2_q.scl & scl_p_q & sda_p_q & ~pin_s2_q.sda;
    assign stop_ev = pin_s2_q.scl & scl_p_q & ~sda_p_q & pin_s2_q.sda;
    assign bit_in = pin_s2_q.sda;
    assign wp_on = pin_s2_q.wp;
    assign enable = ctrl_q[`TW_CTRL_EN_BIT];

    // bytes arrive msb first, new bit at the bottom
    assign rx_byte = {rx_q[6:0], bit_in};
    assign byte_done = is_rx(state_q) & scl_rise & (cnt_q == `TW_LAST_BIT);
    assign dev_hit = (rx_byte[7:4] == DEV_TYPE);
    assign wr_commit = (state_q == tw_mem_pkg::TW_WR) & byte_done & ~wp_on;
    assign rd_done = (state_q == tw_mem_pkg::TW_RD) & scl_rise & (cnt_q == `TW_LAST_BIT);

    // ----------------------------------------
    // protocol state machine
    // ----------------------------------------
    // start and stop override every state; data moves on scl edges
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= tw_mem_pkg::TW_IDLE;
            nxt_q <= tw_mem_pkg::TW_IDLE;
            cnt_q <= `TW_CNT_RST;
            rx_q <= `TW_BYTE_RST;
            tx_q <= `TW_BYTE_RST;
            ack_ok_q <= 1'b0;
            ack_on_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (start_ev) begin
            // a pending write byte is dropped: nothing reached the array
            state_q <= enable ? tw_mem_pkg::TW_DEV : tw_mem_pkg::TW_IDLE;
            cnt_q <= `TW_CNT_RST;
            ack_on_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (stop_ev) begin
            state_q <= tw_mem_pkg::TW_IDLE;
            cnt_q <= `TW_CNT_RST;
            ack_on_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            case (state_q)
                tw_mem_pkg::TW_DEV, tw_mem_pkg::TW_WORD, tw_mem_pkg::TW_WR: begin
                    if (scl_rise) begin
                        rx_q <= rx_byte;
                        cnt_q <= cnt_q + `TW_CNT_ONE;
                    end
                    if (byte_done) begin
                        cnt_q <= `TW_CNT_RST;
                        ack_on_q <= 1'b0;
                        state_q <= tw_mem_pkg::TW_ACK;
                        if (state_q == tw_mem_pkg::TW_DEV) begin
                            ack_ok_q <= dev_hit;
                            // bit 0 set asks for a read, no word address follows
                            nxt_q <= rx_byte[0] ? tw_mem_pkg::TW_RD : tw_mem_pkg::TW_WORD;
                            tx_q <= mem[{rx_byte[3:1], addr_q[7:0]}];
                            if (!dev_hit) begin
                                state_q <= tw_mem_pkg::TW_SKIP;
                            end
                        end else if (state_q == tw_mem_pkg::TW_WORD) begin
                            ack_ok_q <= 1'b1;
                            nxt_q <= tw_mem_pkg::TW_WR;
                        end else begin
                            ack_ok_q <= ~wp_on;
                            nxt_q <= tw_mem_pkg::TW_WR;
                        end
                    end
                end
                tw_mem_pkg::TW_ACK: begin
                    // first fall opens the ack slot, second closes it
                    if (scl_fall) begin
                        if (!ack_on_q) begin
                            ack_on_q <= 1'b1;
                            oe_n_q <= ~ack_ok_q;
                        end else begin
                            ack_on_q <= 1'b0;
                            cnt_q <= `TW_CNT_RST;
                            if (!ack_ok_q) begin
                                state_q <= tw_mem_pkg::TW_SKIP;
                                oe_n_q <= 1'b1;
                            end else begin
                                state_q <= nxt_q;
                                // a read puts its first bit out on this very fall
                                oe_n_q <= (nxt_q == tw_mem_pkg::TW_RD) ? tx_q[7] : 1'b1;
                            end
                        end
                    end
                end
                tw_mem_pkg::TW_RD: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + `TW_CNT_ONE;
                    end
                    // ones are sent by releasing, never by driving high
                    if (scl_fall) begin
                        if (cnt_q == `TW_ACK_BIT) begin
                            oe_n_q <= 1'b1;
                            state_q <= tw_mem_pkg::TW_RACK;
                        end else begin
                            oe_n_q <= bit_sel(tx_q, cnt_q);
                        end
                    end
                end
                tw_mem_pkg::TW_RACK: begin
                    // master ack fetches the next byte, nack ends the read
                    if (scl_rise) begin
                        cnt_q <= `TW_CNT_RST;
                        if (!bit_in) begin
                            state_q <= tw_mem_pkg::TW_RD;
                            tx_q <= mem[addr_q];
                        end else begin
                            state_q <= tw_mem_pkg::TW_SKIP;
                        end
                    end
                end
                tw_mem_pkg::TW_IDLE, tw_mem_pkg::TW_SKIP: begin
                    oe_n_q <= 1'b1;
                end
                default: begin
                    state_q <= tw_mem_pkg::TW_IDLE;
                    oe_n_q <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // address latch
    // ----------------------------------------
    // the low byte survives across operations so reads continue on
    always_ff @(posedge clock) begin
        if (srst) begin
            addr_q <= `TW_ADDR_RST;
        end else if ((state_q == tw_mem_pkg::TW_DEV) && byte_done && dev_hit) begin
            addr_q <= {rx_byte[3:1], addr_q[7:0]};
        end else if ((state_q == tw_mem_pkg::TW_WORD) && byte_done) begin
            addr_q <= {addr_q[10:8], rx_byte};
        end else if (wr_commit || rd_done) begin
            // 11-bit add wraps from the top location to zero by itself
            addr_q <= addr_q + `TW_ADDR_ONE;
        end
    end

    // ----------------------------------------
    // array
    // ----------------------------------------
    // no reset: contents stand for nonvolatile storage
    always_ff @(posedge clock) begin
        if (wr_commit) begin
            mem[addr_q] <= rx_byte;
        end
    end

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    assign wb_req_hit = wb_req.cyc & wb_req.stb & ~wb_ack_q;

    // status view of the front end, rebuilt every cycle
    always_comb begin
        status = `TW_WORD_RST;
        status[`TW_ADDR_W-1:0] = addr_q;
        status[`TW_ST_BUSY_BIT] = (state_q != tw_mem_pkg::TW_IDLE);
        status[`TW_ST_WP_BIT] = wp_on;
    end

    // one wait-free answer per request; ack drops the cycle after
    always_ff @(posedge clock) begin
        if (srst) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= `TW_WORD_RST;
        end else begin
            wb_ack_q <= wb_req_hit;
            if (wb_req_hit && !wb_req.we) begin
                if (wb_req.adr == `TW_REG_STATUS) begin
                    wb_dat_q <= status;
                end else if (wb_req.adr == `TW_REG_CTRL) begin
                    wb_dat_q <= ctrl_q;
                end else begin
                    wb_dat_q <= `TW_WORD_RST;
                end
            end
        end
    end

    // enable gates new operations only; one in flight runs out
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_q <= `TW_CTRL_RST;
        end else if (wb_req_hit && wb_req.we && wb_req.sel[0] && (wb_req.adr == `TW_REG_CTRL)) begin
            ctrl_q <= {31'h0000_0000, wb_req.dat[`TW_CTRL_EN_BIT]};
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // the data pin is open drain: the driven level is always low
    always_ff @(posedge clock) begin
        if (srst) begin
            sda_level <= 1'b0;
        end else begin
            sda_level <= 1'b0;
        end
    end

    assign sda_oe_n = oe_n_q;
    assign wb_ack = wb_ack_q;
    assign wb_rdat = wb_dat_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    a_idle_released: assert property (state_q == tw_mem_pkg::TW_IDLE |-> sda_oe_n)
        else $error("data line held while idle");

    a_start_restart: assert property (start_ev && enable |=> state_q == tw_mem_pkg::TW_DEV && sda_oe_n)
        else $error("start did not restart the slave");

    a_stop_to_idle: assert property (stop_ev |=> state_q == tw_mem_pkg::TW_IDLE ##1 sda_oe_n)
        else $error("stop did not end the operation");

    a_drive_on_fall: assert property ($fell(sda_oe_n) |-> $past(scl_fall))
        else $error("data line pulled outside a clock fall");

    a_wp_no_inc: assert property ((state_q == tw_mem_pkg::TW_WR) && byte_done && wp_on
        |=> addr_q == $past(addr_q) ##1 ack_ok_q == 1'b0)
        else $error("protected write moved the address");

    a_wr_inc: assert property (wr_commit |=> addr_q == $past(addr_q) + `TW_ADDR_ONE)
        else $error("write did not step the address");

    a_wr_commit: assert property (wr_commit |=> mem[$past(addr_q)] == $past(rx_byte))
        else $error("byte not committed to the array");

    a_foreign_quiet: assert property ((state_q == tw_mem_pkg::TW_DEV) && byte_done && !dev_hit
        |=> state_q == tw_mem_pkg::TW_SKIP && sda_oe_n)
        else $error("slave answered a foreign device type");

    a_nack_ends: assert property ((state_q == tw_mem_pkg::TW_RACK) && scl_rise && bit_in
        |=> state_q == tw_mem_pkg::TW_SKIP [*2])
        else $error("read went on after a nack");

    a_wb_ack_pulse: assert property (wb_ack |=> !wb_ack)
        else $error("bus ack held longer than a cycle");

    c_write_byte: cover property (wr_commit);
    c_read_next: cover property ((state_q == tw_mem_pkg::TW_RACK) && scl_rise && !bit_in);
    c_random_read: cover property ((state_q == tw_mem_pkg::TW_WORD) && byte_done ##[1:1000] start_ev);

endmodule

// ==== dv/tw_mem_master.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// two-wire bus master model
// ----------------------------------------
module tw_mem_master (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // both lines released at idle; the clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // start, also used as repeated start: data falls while the clock is high
    task automatic start_cond();
        tick(1);
        sda_low <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sda_low <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(4);
    endtask

    // stop is only called after an ack slot, never mid read data
    task automatic stop_cond();
        tick(1);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sda_low <= 1'b0;
        tick(8);
    endtask

    // data set mid-low and held through the whole high phase
    task automatic bit_out(input logic b);
        sda_low <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(4);
    endtask

    // line released so the device can drive; sampled mid-high
    task automatic bit_in(output logic b);
        sda_low <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        b = sda;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask

    // a nack on the last wanted byte keeps the device off the line at stop
    task automatic recv_byte(input logic give_ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(~give_ack);
    endtask
endmodule

// ==== dv/tw_mem_slave_bench.sv ====
`timescale 1ns/1ns
module tw_mem_slave_bench;
    localparam logic [3:0] DEV = 4'h6; // device-type code, value is arbitrary
    logic clock;
    logic srst;
    logic wp;
    logic scl;
    logic sda_low;
    logic sda;
    logic sda_level;
    logic sda_oe_n;
    logic wb_ack;
    logic [31:0] wb_rdat;
    logic [31:0] rd;
    logic [7:0] byt;
    logic ack;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    tw_mem_pkg::tw_pins_s pins;
    tw_mem_pkg::tw_wb_req_s wb_req;

    // ----------------------------------------
    // wiring
    // ----------------------------------------
    // open-drain data line with pull-up
    assign sda = (sda_low | ~sda_oe_n) ? 1'b0 : 1'b1;
    assign pins = '{scl: scl, sda: sda, wp: wp};

    tw_mem_slave #(.DEV_TYPE(DEV)) dut (
        .clock(clock), .srst(srst), .pins(pins), .sda_level(sda_level), .sda_oe_n(sda_oe_n),
        .wb_req(wb_req), .wb_ack(wb_ack), .wb_rdat(wb_rdat)
    );
    tw_mem_master m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ack is sampled at the rising edge; the request stands until that edge, then drops
    task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
        @(posedge clock);
        while (wb_ack !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        check("wb ack", 32'(wb_ack), 32'h1);
        q = wb_rdat;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
    endtask

    task automatic hdr(input logic [2:0] page, input logic dir, input logic exp_ack);
        m.start_cond();
        m.send_byte({DEV, page, dir}, ack);
        check("addr ack", 32'(ack), 32'(exp_ack));
    endtask

    task automatic wr(input logic [7:0] d, input logic exp_ack);
        m.send_byte(d, ack);
        check("byte ack", 32'(ack), 32'(exp_ack));
    endtask

    task automatic rd_byte(input logic give_ack, input logic [7:0] exp);
        m.recv_byte(give_ack, byt);
        check("read byte", 32'(byt), 32'(exp));
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        wp = 1'b0;
        wb_req = '0;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        check("idle oe_n", 32'(sda_oe_n), 32'h1);
        wb_xfer(1'b0, 32'h0, 32'h0, rd);
        check("status reset", rd, 32'h0);
        wb_xfer(1'b0, 32'h4, 32'h0, rd);
        check("ctrl reset", rd, 32'h1);
        wb_xfer(1'b0, 32'h8, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        // sequential write over the top of the array
        hdr(3'h7, 1'b0, 1'b1);
        check("pull only", 32'(sda_level), 32'h0);
        wr(8'hFE, 1'b1);
        wr(8'hA5, 1'b1);
        wr(8'h3C, 1'b1);
        wr(8'h96, 1'b1);
        wr(8'h5A, 1'b1);
        m.stop_cond();
        wb_xfer(1'b0, 32'h0, 32'h0, rd);
        check("latch wrap", 32'(rd[10:0]), 32'h002);
        check("idle after stop", 32'(rd[16]), 32'h0);
        // random read right after the write, no busy wait
        hdr(3'h7, 1'b0, 1'b1);
        wr(8'hFE, 1'b1);
        hdr(3'h7, 1'b1, 1'b1);
        rd_byte(1'b1, 8'hA5);
        rd_byte(1'b1, 8'h3C);
        rd_byte(1'b0, 8'h96);
        m.stop_cond();
        // current read: page from the address byte, row from the latch
        hdr(3'h0, 1'b1, 1'b1);
        rd_byte(1'b0, 8'h5A);
        rd_byte(1'b0, 8'hFF);
        m.stop_cond();
        // byte cut short by a start leaves the array alone
        hdr(3'h7, 1'b0, 1'b1);
        wr(8'hFF, 1'b1);
        for (int i = 0; i < 5; i++) begin
            m.bit_out(1'b0);
        end
        hdr(3'h7, 1'b1, 1'b1);
        rd_byte(1'b0, 8'h3C);
        m.stop_cond();
        // protected write is refused and the latch holds
        @(posedge clock);
        wp <= 1'b1;
        hdr(3'h7, 1'b0, 1'b1);
        wr(8'hFE, 1'b1);
        wr(8'h00, 1'b0);
        m.stop_cond();
        wb_xfer(1'b0, 32'h0, 32'h0, rd);
        check("latch held", 32'(rd[10:0]), 32'h7FE);
        check("wp seen", 32'(rd[17]), 32'h1);
        @(posedge clock);
        wp <= 1'b0;
        hdr(3'h7, 1'b0, 1'b1);
        wr(8'hFE, 1'b1);
        hdr(3'h7, 1'b1, 1'b1);
        rd_byte(1'b0, 8'hA5);
        m.stop_cond();
        // foreign device type gets no answer
        m.start_cond();
        m.send_byte({~DEV, 3'h0, 1'b0}, ack);
        check("foreign addr", 32'(ack), 32'h0);
        wr(8'h12, 1'b0);
        m.stop_cond();
        // disabled front end ignores start
        wb_xfer(1'b1, 32'h4, 32'h0, rd);
        wb_xfer(1'b0, 32'h4, 32'h0, rd);
        check("ctrl off", rd, 32'h0);
        hdr(3'h7, 1'b1, 1'b0);
        m.stop_cond();
        wb_xfer(1'b1, 32'h4, 32'h1, rd);
        hdr(3'h7, 1'b1, 1'b1);
        rd_byte(1'b0, 8'h3C);
        m.stop_cond();
        wrap_up();
    end
endmodule
